/* cmos_sequencer.v */
// scan sequencer, operating mode and output gating for the process controller
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "cmos_regs.vh"

// Summary of operation
// R1: inputs latched before each scan starts
// R2: block order decides input update point
// R3: outputs update at scan end, except proportioning; step drives also update per block
// R4: three modes held as state
// R5: program mode forces outputs off
// R6: program mode scans I/O, runs no blocks
// R7: run mode scans, executes, drives outputs
// R8: offline entered only from run
// R9: offline scans, no blocks, outputs frozen
// R10: offline-to-run restart on new firmware
// R11: run permits download, forces; refuses calibration
// R12: program permits calibration, downloads; no forces
// R13: offline permits input calibration, forces
// R14: off state: low, zero duty, drives off
// R15: frozen state holds, step drives off
// R16: locked run rejects safety writes, changes
// R17: run utilities need unlocked switch; forces are granted in locked run too
// R18: first 100 blocks reserved for system
// R19: switch overrides operator mode requests
// R20: mode changes only at scan boundary
module cmos_sequencer #(
    parameter N_IN = 16,
    parameter N_DO = 16,
    parameter N_AO = 4,
    parameter AO_W = 16,
    parameter BLK_W = 10
) (
    input wire clk,
    input wire reset_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // physical switch and field inputs (asynchronous)
    input wire [1:0] mode_switch,
    input wire [N_IN-1:0] field_in,
    // block engine interface
    input wire scan_start,
    output reg [N_IN-1:0] scan_inputs,
    output reg blk_valid,
    output reg [BLK_W-1:0] blk_number,
    output reg blk_user,
    input wire blk_done,
    // algorithm results
    input wire [N_DO-1:0] alg_do,
    input wire [N_DO-1:0] alg_tpo_duty_on,
    input wire [N_DO-1:0] alg_is_direct,
    input wire [N_AO*AO_W-1:0] alg_ao,
    input wire alg_fwd,
    input wire alg_rev,
    // physical outputs
    output reg [N_DO-1:0] digital_out,
    output reg [N_AO*AO_W-1:0] analog_output_channel,
    output reg step_fwd,
    output reg step_rev,
    // status
    output reg [1:0] mode,
    output reg scanning,
    output reg restart_pulse,
    output wire [6:0] utility_ok
);

    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_END = 2'h2;

    reg [N_IN-1:0] in_meta;
    reg [N_IN-1:0] in_sync;
    reg [1:0] sw_meta;
    reg [1:0] sw_sync;
    reg [1:0] state;
    reg [1:0] next_mode;
    reg [BLK_W-1:0] seq_len;
    reg [1:0] op_req;
    reg op_pending;
    reg new_fw;
    reg [6:0] util_req;
    reg [6:0] util_grant;
    reg [15:0] scan_count;
    reg [N_DO-1:0] do_stage;
    reg [N_AO*AO_W-1:0] ao_stage;
    wire exec_blocks;

    // permitted utility set per mode and switch position
    function [6:0] cmos_allow;
        input [1:0] m;
        input [1:0] sw;
        begin
            cmos_allow = 7'h00;
            case (m)
                `CMOS_MODE_RUN: begin
                    if (sw == `CMOS_SW_UNLOCKED) begin
                        cmos_allow[`CMOS_UT_CFG_DL] = 1'b1; // R11
                        cmos_allow[`CMOS_UT_SAFE_WR] = 1'b1;
                        cmos_allow[`CMOS_UT_CFG_CHG] = 1'b1; // R17
                    end
                    cmos_allow[`CMOS_UT_FORCE_LED] = 1'b1; // R11
                    // R16: locked run leaves safety writes and changes refused
                end
                `CMOS_MODE_PROGRAM: begin
                    cmos_allow[`CMOS_UT_AI_CAL] = 1'b1; // R12
                    cmos_allow[`CMOS_UT_AO_CAL] = 1'b1;
                    cmos_allow[`CMOS_UT_CFG_DL] = 1'b1;
                    cmos_allow[`CMOS_UT_FW_DL] = 1'b1;
                    cmos_allow[`CMOS_UT_CFG_CHG] = 1'b1;
                end
                `CMOS_MODE_OFFLINE: begin
                    cmos_allow[`CMOS_UT_AI_CAL] = 1'b1; // R13
                    cmos_allow[`CMOS_UT_FORCE_LED] = 1'b1;
                end
                default: cmos_allow = 7'h00;
            endcase
        end
    endfunction

    assign utility_ok = cmos_allow(mode, sw_sync);
    // R6 R7 R9
    assign exec_blocks = (mode == `CMOS_MODE_RUN);

    // two-flop synchronisers for pins
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_meta <= {N_IN{1'b0}};
            in_sync <= {N_IN{1'b0}};
            sw_meta <= `CMOS_SW_PROG_LOCK;
            sw_sync <= `CMOS_SW_PROG_LOCK;
        end else begin
            in_meta <= field_in;
            in_sync <= in_meta;
            sw_meta <= mode_switch;
            sw_sync <= sw_meta;
        end
    end

    // mode target: switch first, operator request only in unlocked position
    always @* begin
        next_mode = mode;
        case (sw_sync)
            `CMOS_SW_PROG_LOCK: next_mode = `CMOS_MODE_PROGRAM; // R19
            `CMOS_SW_RUN_LOCK: begin
                if (mode != `CMOS_MODE_RUN)
                    next_mode = `CMOS_MODE_RUN; // R19
            end
            `CMOS_SW_UNLOCKED: begin
                if (op_pending) begin
                    if (op_req == `CMOS_MODE_OFFLINE) begin
                        if (mode == `CMOS_MODE_RUN)
                            next_mode = `CMOS_MODE_OFFLINE; // R8
                    end else if (op_req == `CMOS_MODE_RUN || op_req == `CMOS_MODE_PROGRAM) begin
                        next_mode = op_req;
                    end
                end
            end
            default: next_mode = mode;
        endcase
    end

    // scan engine: latch inputs, walk blocks, commit outputs
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            mode <= `CMOS_MODE_PROGRAM;
            scanning <= 1'b0;
            scan_inputs <= {N_IN{1'b0}};
            blk_valid <= 1'b0;
            blk_number <= {BLK_W{1'b0}};
            blk_user <= 1'b0;
            do_stage <= {N_DO{1'b0}};
            ao_stage <= {(N_AO*AO_W){1'b0}};
            digital_out <= {N_DO{1'b0}};
            analog_output_channel <= {(N_AO*AO_W){1'b0}};
            step_fwd <= 1'b0;
            step_rev <= 1'b0;
            restart_pulse <= 1'b0;
            scan_count <= 16'h0000;
            op_pending <= 1'b0;
        end else begin
            restart_pulse <= 1'b0;
            if (reg_wr && reg_addr == `CMOS_ADDR_CTRL && reg_wdata[`CMOS_CTRL_REQ_STB])
                op_pending <= 1'b1;
            case (state)
                ST_IDLE: begin
                    if (scan_start) begin
                        // mode only moves here, between scans
                        mode <= next_mode; // R20
                        if (op_pending && !(reg_wr && reg_addr == `CMOS_ADDR_CTRL))
                            op_pending <= 1'b0;
                        // newer firmware restarts from offline: outputs de-energised first
                        if (mode == `CMOS_MODE_OFFLINE && next_mode == `CMOS_MODE_RUN
                                && new_fw) begin
                            restart_pulse <= 1'b1; // R10
                            digital_out <= {N_DO{1'b0}}; // R10
                            analog_output_channel <= {(N_AO*AO_W){1'b0}};
                            step_fwd <= 1'b0;
                            step_rev <= 1'b0;
                        end
                        scan_inputs <= in_sync; // R1
                        scanning <= 1'b1;
                        blk_number <= {BLK_W{1'b0}};
                        blk_user <= 1'b0;
                        blk_valid <= (next_mode == `CMOS_MODE_RUN);
                        state <= (next_mode == `CMOS_MODE_RUN) ? ST_EXEC : ST_END;
                    end
                end
                ST_EXEC: begin
                    if (blk_done) begin
                        // R2: each block sees values set by earlier ones in order
                        do_stage <= alg_do;
                        ao_stage <= alg_ao;
                        // proportioning and step outputs drive while running
                        digital_out <= (digital_out & ~alg_is_direct)
                                     | (alg_tpo_duty_on & alg_is_direct); // R3
                        step_fwd <= alg_fwd; // R3
                        step_rev <= alg_rev;
                        if (blk_number + 1'b1 >= seq_len) begin
                            blk_valid <= 1'b0;
                            state <= ST_END;
                        end else begin
                            blk_number <= blk_number + 1'b1;
                            // R18: numbers below the system range are not user blocks
                            blk_user <= (blk_number + 1'b1 >= `CMOS_SYS_BLOCKS);
                        end
                    end
                end
                ST_END: begin
                    scanning <= 1'b0;
                    scan_count <= scan_count + 16'h0001;
                    state <= ST_IDLE;
                    case (mode)
                        `CMOS_MODE_RUN: begin
                            digital_out <= (do_stage & ~alg_is_direct)
                                         | (digital_out & alg_is_direct); // R3
                            analog_output_channel <= ao_stage; // R7
                        end
                        `CMOS_MODE_OFFLINE: begin
                            // hold last levels and duty, stop the motor
                            step_fwd <= 1'b0; // R15
                            step_rev <= 1'b0; // R9
                        end
                        default: begin
                            digital_out <= {N_DO{1'b0}}; // R14
                            analog_output_channel <= {(N_AO*AO_W){1'b0}}; // R5
                            step_fwd <= 1'b0;
                            step_rev <= 1'b0;
                        end
                    endcase
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // software registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op_req <= `CMOS_MODE_PROGRAM;
            new_fw <= 1'b1;
            seq_len <= `CMOS_SEQ_LEN_RESET;
            util_req <= 7'h00;
            util_grant <= 7'h00;
        end else begin
            util_grant <= util_req & cmos_allow(mode, sw_sync); // R16
            if (reg_wr) begin
                case (reg_addr)
                    `CMOS_ADDR_CTRL: begin
                        op_req <= reg_wdata[`CMOS_CTRL_REQ_HI:`CMOS_CTRL_REQ_LO];
                        new_fw <= reg_wdata[`CMOS_CTRL_NEW_FW];
                    end
                    `CMOS_ADDR_SEQ_LEN: begin
                        // a sequence no longer than the system blocks is not allowed
                        if (reg_wdata[BLK_W-1:0] > `CMOS_SYS_BLOCKS)
                            seq_len <= reg_wdata[BLK_W-1:0]; // R18
                    end
                    `CMOS_ADDR_UTIL_REQ: util_req <= reg_wdata[6:0];
                    default: util_req <= util_req;
                endcase
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `CMOS_ADDR_CTRL:
                    reg_rdata <= {28'h0000000, new_fw, 1'b0, op_req};
                `CMOS_ADDR_STATUS:
                    reg_rdata <= {24'h000000, sw_sync, op_pending, scanning, state, mode};
                `CMOS_ADDR_SEQ_LEN:
                    reg_rdata <= {{(32-BLK_W){1'b0}}, seq_len};
                `CMOS_ADDR_UTIL_REQ:
                    reg_rdata <= {25'h0000000, util_req};
                `CMOS_ADDR_UTIL_OK:
                    reg_rdata <= {25'h0000000, util_grant};
                `CMOS_ADDR_SCANS:
                    reg_rdata <= {16'h0000, scan_count};
                default:
                    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

/* cmos_regs.vh */
// register offsets, field positions, reset values and codes for the mode/output sequencer
`ifndef CMOS_REGS_VH
`define CMOS_REGS_VH

// register addresses (word index on the plain port)
`define CMOS_ADDR_CTRL      4'h0
`define CMOS_ADDR_STATUS    4'h1
`define CMOS_ADDR_SEQ_LEN   4'h2
`define CMOS_ADDR_UTIL_REQ  4'h3
`define CMOS_ADDR_UTIL_OK   4'h4
`define CMOS_ADDR_SCANS     4'h5

// ctrl register fields
`define CMOS_CTRL_REQ_LO     0
`define CMOS_CTRL_REQ_HI     1
`define CMOS_CTRL_REQ_STB    2
`define CMOS_CTRL_NEW_FW     3
`define CMOS_CTRL_RESET      32'h0000_0008

// mode codes
`define CMOS_MODE_PROGRAM   2'h0
`define CMOS_MODE_RUN       2'h1
`define CMOS_MODE_OFFLINE   2'h2

// switch position codes
`define CMOS_SW_PROG_LOCK   2'h0
`define CMOS_SW_UNLOCKED    2'h1
`define CMOS_SW_RUN_LOCK    2'h2

// utility function bits
`define CMOS_UT_CFG_DL      0
`define CMOS_UT_FW_DL       1
`define CMOS_UT_AI_CAL      2
`define CMOS_UT_AO_CAL      3
`define CMOS_UT_FORCE_LED   4
`define CMOS_UT_SAFE_WR     5
`define CMOS_UT_CFG_CHG     6

// block numbering
`define CMOS_SYS_BLOCKS     10'h064
`define CMOS_SEQ_LEN_RESET  10'h0c8

`endif

/* cmos_seq_sva.sv */
// port-level assertions for the mode/output sequencer
`timescale 1ns/1ps
`include "cmos_regs.vh"
module cmos_seq_chk #(
    parameter N_DO = 16,
    parameter N_AO = 4,
    parameter AO_W = 16,
    parameter BLK_W = 10
) (
    input wire clk,
    input wire reset_n,
    input wire [1:0] mode,
    input wire scanning,
    input wire blk_valid,
    input wire [BLK_W-1:0] blk_number,
    input wire blk_user,
    input wire [N_DO-1:0] digital_out,
    input wire [N_AO*AO_W-1:0] analog_output_channel,
    input wire step_fwd,
    input wire step_rev,
    input wire restart_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_mode_legal; mode != 2'h3; endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("bad mode code");
    property p_prog_off; (mode == `CMOS_MODE_PROGRAM && !scanning) |->
        (digital_out == 0 && analog_output_channel == 0 && !step_fwd && !step_rev); endproperty
    a_prog_off: assert property (p_prog_off) else $error("outputs live in program");
    property p_no_blk; blk_valid |-> mode == `CMOS_MODE_RUN; endproperty
    a_no_blk: assert property (p_no_blk) else $error("block run outside run");
    property p_off_entry; (mode == `CMOS_MODE_OFFLINE && $past(mode) != `CMOS_MODE_OFFLINE)
        |-> $past(mode) == `CMOS_MODE_RUN; endproperty
    a_off_entry: assert property (p_off_entry) else $error("offline not from run");
    property p_mode_edge; $changed(mode) |-> $rose(scanning); endproperty
    a_mode_edge: assert property (p_mode_edge) else $error("mode moved mid scan");
    property p_frozen; (mode == `CMOS_MODE_OFFLINE && $past(mode) == `CMOS_MODE_OFFLINE)
        |-> $stable(digital_out) && $stable(analog_output_channel); endproperty
    a_frozen: assert property (p_frozen) else $error("offline outputs moved");
    property p_step_off; (mode == `CMOS_MODE_OFFLINE && !scanning) |-> !step_fwd && !step_rev;
    endproperty
    a_step_off: assert property (p_step_off) else $error("step drive on offline");
    property p_user; blk_valid |-> blk_user == (blk_number >= 100); endproperty
    a_user: assert property (p_user) else $error("user split wrong");
    property p_out_end; $changed(analog_output_channel) |->
        $fell(scanning) || restart_pulse || $past(restart_pulse); endproperty
    a_out_end: assert property (p_out_end) else $error("analog moved mid scan");
    property p_restart; restart_pulse |-> mode == `CMOS_MODE_RUN ##1 !restart_pulse;
    endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
endmodule
bind cmos_sequencer cmos_seq_chk #(.N_DO(N_DO), .N_AO(N_AO), .AO_W(AO_W), .BLK_W(BLK_W)) u_chk (
    .clk(clk), .reset_n(reset_n), .mode(mode), .scanning(scanning), .blk_valid(blk_valid),
    .blk_number(blk_number), .blk_user(blk_user), .digital_out(digital_out),
    .analog_output_channel(analog_output_channel), .step_fwd(step_fwd), .step_rev(step_rev),
    .restart_pulse(restart_pulse));

/* cmos_io_model.sv */
// block engine model answering each block request after a chosen wait
`timescale 1ns/1ps
module cmos_io_model (
    input wire clk,
    input wire reset_n,
    input wire blk_valid,
    input wire [3:0] wait_cycles,
    output reg blk_done
);
    reg [3:0] cnt;
    // never two pulses in a row, so the index has a cycle to advance
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 4'h0;
            blk_done <= 1'b0;
        end else if (blk_valid && !blk_done && cnt >= wait_cycles) begin
            cnt <= 4'h0;
            blk_done <= 1'b1;
        end else begin
            cnt <= blk_valid ? cnt + 4'h1 : 4'h0;
            blk_done <= 1'b0;
        end
    end
endmodule

/* tb.sv */
// self-checking bench for the mode/output sequencer
`timescale 1ns/1ps
`include "cmos_regs.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [1:0] mode_switch = `CMOS_SW_UNLOCKED;
    reg [15:0] field_in = 16'h5a3c;
    reg scan_start = 1'b0;
    reg [15:0] alg_do = 16'hbeef;
    reg [63:0] alg_ao = 64'h0123_4567_89ab_cdef;
    reg [3:0] wait_cycles = 4'h2;
    wire [31:0] reg_rdata;
    wire [15:0] scan_inputs, digital_out;
    wire [63:0] analog_output_channel;
    wire [9:0] blk_number;
    wire [1:0] mode;
    wire [6:0] utility_ok;
    wire blk_valid, blk_user, blk_done, step_fwd, step_rev, scanning, restart_pulse;
    integer fail_count = 0;
    integer compares = 0;
    integer nblk, restarts, first_user, n;
    reg [15:0] dout_mid;
    reg [31:0] rdv;
    always #5 clk = ~clk;
    cmos_sequencer dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mode_switch(mode_switch), .field_in(field_in), .scan_start(scan_start),
        .scan_inputs(scan_inputs), .blk_valid(blk_valid), .blk_number(blk_number),
        .blk_user(blk_user), .blk_done(blk_done), .alg_do(alg_do), .alg_tpo_duty_on(16'h0),
        .alg_is_direct(16'h0), .alg_ao(alg_ao), .alg_fwd(1'b1), .alg_rev(1'b0),
        .digital_out(digital_out), .analog_output_channel(analog_output_channel),
        .step_fwd(step_fwd), .step_rev(step_rev), .mode(mode), .scanning(scanning),
        .restart_pulse(restart_pulse), .utility_ok(utility_ok));
    cmos_io_model io (.clk(clk), .reset_n(reset_n), .blk_valid(blk_valid),
        .wait_cycles(wait_cycles), .blk_done(blk_done));
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 rdv = reg_rdata;
        end
    endtask
    // inputs flip right after the scan is taken, so a tracking latch shows up
    task scan;
        begin
            nblk = 0;
            restarts = 0;
            first_user = -1;
            n = 0;
            @(posedge clk);
            scan_start <= 1'b1;
            @(posedge clk);
            scan_start <= 1'b0;
            field_in <= ~field_in;
            #1 dout_mid = digital_out;
            while (scanning === 1'b1 && n < 2000) begin
                if (blk_done && blk_valid) nblk++;
                if (restart_pulse) restarts++;
                if (blk_user && first_user < 0) first_user = blk_number;
                @(posedge clk);
                #1 n++;
            end
            if (restart_pulse) restarts++;
            if (n >= 2000) fail_count++;
        end
    endtask
    task final_report;
        begin
            $display("compares %0d fail_count %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #400000;
        fail_count++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        #1 `CHK("mode", `CMOS_MODE_PROGRAM, mode)
        rd(`CMOS_ADDR_CTRL);
        `CHK("ctrl", 32'h0000_0008, rdv)
        rd(4'hf);
        `CHK("unmapped", 32'h0, rdv)
        rd(`CMOS_ADDR_SEQ_LEN);
        `CHK("seq len", 32'h0000_00c8, rdv)
        wr(`CMOS_ADDR_SEQ_LEN, 32'h0000_0064);
        rd(`CMOS_ADDR_SEQ_LEN);
        `CHK("seq len kept", 32'h0000_00c8, rdv)
        wr(`CMOS_ADDR_SEQ_LEN, 32'h0000_0065);
        scan;
        `CHK("prog blocks", 0, nblk)
        `CHK("latched", 16'h5a3c, scan_inputs)
        `CHK("prog do", 16'h0, digital_out)
        `CHK("prog ao", 64'h0, analog_output_channel)
        `CHK("prog step", 2'b00, {step_fwd, step_rev})
        `CHK("prog util", 5'h0f, utility_ok[4:0])
        wr(`CMOS_ADDR_UTIL_REQ, 32'h0000_007f);
        rd(`CMOS_ADDR_UTIL_REQ);
        `CHK("util req", 32'h0000_007f, rdv)
        rd(`CMOS_ADDR_UTIL_OK);
        `CHK("util grant", 32'h0000_004f, rdv)
        wr(`CMOS_ADDR_CTRL, 32'h0000_000e);
        scan;
        `CHK("no offline", `CMOS_MODE_PROGRAM, mode)
        @(posedge clk);
        field_in <= 16'hc3a5;
        wr(`CMOS_ADDR_CTRL, 32'h0000_000d);
        scan;
        `CHK("run mode", `CMOS_MODE_RUN, mode)
        `CHK("run blocks", 101, nblk)
        `CHK("first user", 100, first_user)
        `CHK("held mid scan", 16'h0, dout_mid)
        `CHK("run do", 16'hbeef, digital_out)
        `CHK("run ao", 64'h0123_4567_89ab_cdef, analog_output_channel)
        `CHK("run fwd", 1'b1, step_fwd)
        `CHK("run latched", 16'hc3a5, scan_inputs)
        `CHK("run util", 4'b1001, {utility_ok[4:2], utility_ok[0]})
        @(posedge clk);
        wait_cycles <= 4'h0;
        wr(`CMOS_ADDR_CTRL, 32'h0000_000e);
        scan;
        `CHK("offline", `CMOS_MODE_OFFLINE, mode)
        @(posedge clk);
        alg_do <= 16'h1234;
        alg_ao <= 64'h0;
        scan;
        `CHK("off blocks", 0, nblk)
        `CHK("frozen do", 16'hbeef, digital_out)
        `CHK("frozen ao", 64'h0123_4567_89ab_cdef, analog_output_channel)
        `CHK("step off", 2'b00, {step_fwd, step_rev})
        `CHK("off util", 3'b101, utility_ok[4:2])
        wr(`CMOS_ADDR_CTRL, 32'h0000_000d);
        scan;
        `CHK("back to run", `CMOS_MODE_RUN, mode)
        `CHK("restart", 1, restarts)
        `CHK("restart off", 16'h0, dout_mid)
        @(posedge clk);
        mode_switch <= `CMOS_SW_RUN_LOCK;
        repeat (3) @(posedge clk);
        #1 `CHK("lock util", 3'b000, {utility_ok[6:5], utility_ok[0]})
        wr(`CMOS_ADDR_CTRL, 32'h0000_000c);
        scan;
        `CHK("lock holds", `CMOS_MODE_RUN, mode)
        @(posedge clk);
        mode_switch <= `CMOS_SW_UNLOCKED;
        wr(`CMOS_ADDR_CTRL, 32'h0000_000c);
        scan;
        `CHK("to program", `CMOS_MODE_PROGRAM, mode)
        `CHK("off again", 16'h0, digital_out)
        rd(`CMOS_ADDR_STATUS);
        `CHK("status", 32'h0000_0040, rdv)
        rd(`CMOS_ADDR_SCANS);
        `CHK("scan count", 32'h0000_0008, rdv)
        final_report;
    end
endmodule
